// [core/sesu_top.sv]
// module: upper status event bits, mask gating and interrupt output
// Function
// - Processor error set when a command arrives before internal logic is ready.
// - Reading row buffer before fetched row arrives raises processor error.
// - Row buffer write during pending row store errors and is discarded.
// - Control packet send during pending row store raises processor error.
// - Row address write during pending row store errors; address kept.
// - Eight consecutive crc or parity errors on a port set out-of-sync.
// - Any toggle of a signal-detect bit sets the signal-detect event.
// - Masked events still set status but never drive the interrupt.
// - Interrupt low only if unmasked event set and output enabled; reset disables.
`timescale 1ns/1ps
`default_nettype none
module sesu_top
	import sesu_pkg::*;
#(
	parameter int NPORTS = sesu_pkg::SESU_NUM_PORTS,
	parameter int ROW_W = 32,
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// management command port operations
	input wire logic row_fetch_cmd,
	input wire logic row_store_cmd,
	input wire logic row_buf_rd,
	input wire logic row_buf_wr,
	input wire logic [ROW_W-1:0] row_buf_wdata,
	input wire logic row_addr_wr,
	input wire logic [ADDR_W-1:0] row_addr_wdata,
	input wire logic ctl_send_cmd,
	input wire logic status_fetch_cmd,
	input wire logic [15:0] mask_reg,
	input wire logic irq_enable,
	// internal memory handshake
	input wire logic fetch_done,
	input wire logic [ROW_W-1:0] fetch_data,
	input wire logic store_done,
	// link error reports
	input wire logic [NPORTS-1:0] pkt_done,
	input wire logic [NPORTS-1:0] crc_err,
	input wire logic [NPORTS-1:0] par_err,
	// line signal-detect pins
	input wire logic [NPORTS-1:0] sig_detect,
	// outputs
	output logic [ROW_W-1:0] row_buf,
	output logic [ADDR_W-1:0] row_addr,
	output logic fetch_pending,
	output logic store_pending,
	output logic [15:0] event_status,
	output logic irq_out_n
);
	typedef struct packed {
		logic [ROW_W-1:0] row_buf;
		logic [ADDR_W-1:0] row_addr;
		logic fetch_pend;
		logic store_pend;
		logic [NPORTS-1:0] sd_s1;
		logic [NPORTS-1:0] sd_s2;
		logic [NPORTS-1:0] sd_prev;
		logic [2:0] sd_warm;
		logic [15:0] status;
		logic irq_n;
	} sesu_state_t;
	sesu_state_t st_ff, nxt_st;
	logic oos_hit;
	logic perr_ev;
	logic sd_ev;
	logic [15:0] set_vec;
	logic [15:0] next_status;
	sesu_sync_cnt #(.NPORTS(NPORTS)) u_sync_cnt (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pkt_done(pkt_done),
		.crc_err(crc_err),
		.par_err(par_err),
		.oos_hit(oos_hit)
	);
	always_comb begin
		nxt_st = st_ff;
		// two-flop sync of signal-detect pins
		nxt_st.sd_s1 = sig_detect;
		nxt_st.sd_s2 = st_ff.sd_s1;
		nxt_st.sd_prev = st_ff.sd_s2;
		// compare only once sync stages and history hold pin values
		nxt_st.sd_warm = {st_ff.sd_warm[1:0], 1'b1};
		sd_ev = st_ff.sd_warm[2] && (st_ff.sd_s2 != st_ff.sd_prev);
		// processor error cases
		perr_ev = (row_buf_rd && st_ff.fetch_pend)
			|| (row_buf_wr && st_ff.store_pend)
			|| (ctl_send_cmd && st_ff.store_pend)
			|| (row_addr_wr && st_ff.store_pend);
		if (fetch_done) begin
			nxt_st.fetch_pend = 1'b0;
			nxt_st.row_buf = fetch_data;
		end
		if (store_done) begin
			nxt_st.store_pend = 1'b0;
		end
		if (row_fetch_cmd) begin
			nxt_st.fetch_pend = 1'b1;
		end
		if (row_store_cmd) begin
			nxt_st.store_pend = 1'b1;
		end
		if (row_buf_wr && !st_ff.store_pend) begin
			nxt_st.row_buf = row_buf_wdata;
		end
		if (row_addr_wr && !st_ff.store_pend) begin
			nxt_st.row_addr = row_addr_wdata;
		end
		set_vec = 16'h0000;
		set_vec[SESU_BIT_PERR] = perr_ev;
		set_vec[SESU_BIT_OOS] = oos_hit;
		set_vec[SESU_BIT_SDET] = sd_ev;
		// read clears, new set wins
		next_status = (status_fetch_cmd ? 16'h0000 : st_ff.status) | set_vec;
		nxt_st.status = next_status & SESU_UPPER_BITS;
		nxt_st.irq_n = !(irq_enable && |(nxt_st.status & ~mask_reg));
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.status <= SESU_STATUS_RST;
			st_ff.irq_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign row_buf = st_ff.row_buf;
	assign row_addr = st_ff.row_addr;
	assign fetch_pending = st_ff.fetch_pend;
	assign store_pending = st_ff.store_pend;
	assign event_status = st_ff.status;
	assign irq_out_n = st_ff.irq_n;

	sequence s_store_wait;
		st_ff.store_pend && row_buf_wr;
	endsequence
	sequence s_fetch_wait;
		st_ff.fetch_pend && row_buf_rd;
	endsequence
	sequence s_fetch_land;
		fetch_done && !row_buf_wr;
	endsequence
	sequence s_store_open;
		row_buf_wr && !st_ff.store_pend;
	endsequence

	a_rowbuf_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_store_wait ##0 !fetch_done |=> row_buf == $past(row_buf))
		else $error("row buffer overwritten during pending store");
	a_wr_perr: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_store_wait |=> event_status[SESU_BIT_PERR])
		else $error("refused row write did not flag error");
	a_rowbuf_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_store_open |=> row_buf == $past(row_buf_wdata))
		else $error("accepted row write not loaded");
	a_addr_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		row_addr_wr && st_ff.store_pend |=> row_addr == $past(row_addr))
		else $error("row address overwritten during pending store");
	a_addr_perr: assert property (@(posedge ref_clk) disable iff (!rst_n)
		row_addr_wr && store_pending |=> event_status[SESU_BIT_PERR])
		else $error("refused address write did not flag error");
	a_addr_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
		row_addr_wr && !store_pending |=> row_addr == $past(row_addr_wdata))
		else $error("accepted address write not loaded");
	a_rd_perr: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_fetch_wait |=> event_status[SESU_BIT_PERR])
		else $error("early row read did not flag error");
	a_fetch_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_fetch_land |=> row_buf == $past(fetch_data))
		else $error("fetched row not loaded");
	a_fetch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fetch_pending && !fetch_done |=> fetch_pending)
		else $error("fetch pending dropped early");
	a_fetch_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fetch_done && !row_fetch_cmd |=> !fetch_pending)
		else $error("fetch pending stuck after done");
	a_store_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
		store_pending && !store_done |=> store_pending)
		else $error("store pending dropped early");
	a_store_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		store_done && !row_store_cmd |=> !store_pending)
		else $error("store pending stuck after done");
	a_send_perr: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ctl_send_cmd && store_pending |=> event_status[SESU_BIT_PERR])
		else $error("send during store did not flag error");
	a_perr_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(event_status[SESU_BIT_PERR]) |-> $past(perr_ev))
		else $error("processor error without cause");
	a_oos_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		oos_hit |=> event_status[SESU_BIT_OOS])
		else $error("out of sync not recorded");
	a_sd_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sd_ev |=> event_status[SESU_BIT_SDET])
		else $error("signal detect change not recorded");
	a_mask_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
		perr_ev && mask_reg[SESU_BIT_PERR] |=> event_status[SESU_BIT_PERR])
		else $error("masked event not recorded");
	a_irq_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(event_status & ~$past(mask_reg)) == 16'h0000 |-> irq_out_n)
		else $error("interrupt driven by masked events only");
	a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!irq_out_n |-> $past(irq_enable) && ($past(mask_reg) & event_status) != event_status)
		else $error("interrupt without unmasked event or enable");
	a_irq_fire: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$past(irq_enable) && (event_status & ~$past(mask_reg)) != 16'h0000 |-> !irq_out_n)
		else $error("unmasked enabled event without interrupt");
	a_irq_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!$past(irq_enable) |-> irq_out_n)
		else $error("interrupt while output disabled");
	a_sticky_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!status_fetch_cmd |=> (event_status & $past(event_status)) == $past(event_status))
		else $error("event bit lost without a status read");
	a_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		status_fetch_cmd && !perr_ev && !oos_hit && !sd_ev |=> event_status == 16'h0000)
		else $error("status read did not clear event bits");
endmodule
`default_nettype wire

// [common/sesu_pkg.sv]
// package: constants for the upper status event block
package sesu_pkg;
	localparam int SESU_STATUS_W = 16;
	localparam int SESU_BIT_PERR = 10;
	localparam int SESU_BIT_OOS = 11;
	localparam int SESU_BIT_SDET = 12;
	localparam int SESU_SYNC_LIMIT = 8;
	localparam int SESU_CNT_W = 4;
	localparam int SESU_NUM_PORTS = 16;
	localparam logic [15:0] SESU_STATUS_RST = 16'h0000;
	localparam logic [15:0] SESU_MASK_RST = 16'h0000;
	localparam logic SESU_IRQ_EN_RST = 1'b0;
	localparam logic [15:0] SESU_UPPER_BITS = 16'h1C00;
endpackage

// [core/sesu_sync_cnt.sv]
// module: per-port run counters of consecutive crc and parity errors
`timescale 1ns/1ps
`default_nettype none
module sesu_sync_cnt
	import sesu_pkg::*;
#(
	parameter int NPORTS = sesu_pkg::SESU_NUM_PORTS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// per-port packet results
	input wire logic [NPORTS-1:0] pkt_done,
	input wire logic [NPORTS-1:0] crc_err,
	input wire logic [NPORTS-1:0] par_err,
	// registered: some port hit the limit in the previous cycle
	output logic oos_hit
);
	typedef struct packed {
		logic [NPORTS-1:0][SESU_CNT_W-1:0] crc_run;
		logic [NPORTS-1:0][SESU_CNT_W-1:0] par_run;
		logic hit;
	} sesu_cnt_state_t;
	sesu_cnt_state_t st_ff, nxt_st;
	localparam logic [SESU_CNT_W-1:0] LIM = SESU_CNT_W'(SESU_SYNC_LIMIT);
	localparam logic [SESU_CNT_W-1:0] ONE = SESU_CNT_W'(1);
	wire logic [NPORTS-1:0] hit_vec;
	wire logic [NPORTS-1:0][SESU_CNT_W-1:0] crc_nxt;
	wire logic [NPORTS-1:0][SESU_CNT_W-1:0] par_nxt;
	genvar gi;
	generate
		for (gi = 0; gi < NPORTS; gi++) begin : g_port
			// runs restart on a clean packet
			wire logic [SESU_CNT_W-1:0] crc_step;
			wire logic [SESU_CNT_W-1:0] par_step;
			assign crc_step = crc_err[gi] ? st_ff.crc_run[gi] + ONE : '0;
			assign par_step = par_err[gi] ? st_ff.par_run[gi] + ONE : '0;
			assign hit_vec[gi] = pkt_done[gi] && (crc_step == LIM || par_step == LIM);
			assign crc_nxt[gi] = !pkt_done[gi] ? st_ff.crc_run[gi] : (hit_vec[gi] ? '0 : crc_step);
			assign par_nxt[gi] = !pkt_done[gi] ? st_ff.par_run[gi] : (hit_vec[gi] ? '0 : par_step);
		end
	endgenerate
	always_comb begin
		nxt_st.crc_run = crc_nxt;
		nxt_st.par_run = par_nxt;
		nxt_st.hit = |hit_vec;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign oos_hit = st_ff.hit;
endmodule
`default_nettype wire

// [test/sesu_mem_model.sv]
// internal memory model answering row fetch and row store
`timescale 1ns/1ps
`default_nettype none
module sesu_mem_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic fetch_cmd,
	input wire logic store_cmd,
	input wire logic [3:0] lat,
	output logic fetch_done,
	output logic [31:0] fetch_data,
	output logic store_done
);
	logic [3:0] fc, sc;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fc <= 4'h0;
			sc <= 4'h0;
		end else begin
			fc <= fetch_cmd ? lat : ((fc != 4'h0) ? fc - 4'h1 : 4'h0);
			sc <= store_cmd ? lat : ((sc != 4'h0) ? sc - 4'h1 : 4'h0);
		end
	end
	assign fetch_done = (fc == 4'h1);
	assign store_done = (sc == 4'h1);
	assign fetch_data = fetch_done ? 32'hA5C3_0F1E : ({28'h0, fc} ^ 32'hFFFF_FFF0);
endmodule
`default_nettype wire

// [test/tb_status_event_sources_upper.sv]
// testbench for the upper status event block
`timescale 1ns/1ps
`default_nettype none
module tb_status_event_sources_upper;
	logic ref_clk = 0, rst_n = 0, fd, sd, irq_enable = 0, irq_n, fpend, spend;
	logic [6:0] cmd = 0;
	logic [3:0] lat = 4'hF, pkt = 0, crc = 0, par = 0, sig = 0;
	logic [31:0] wd = 0, fdat, rbuf;
	logic [11:0] ad = 0, radr;
	logic [15:0] mask = 0, st;
	int fails = 0, check_count = 0;
	sesu_top #(.NPORTS(4)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .row_fetch_cmd(cmd[6]), .row_store_cmd(cmd[5]),
		.row_buf_rd(cmd[4]), .row_buf_wr(cmd[3]), .row_addr_wr(cmd[2]), .ctl_send_cmd(cmd[1]),
		.status_fetch_cmd(cmd[0]), .row_buf_wdata(wd), .row_addr_wdata(ad), .mask_reg(mask),
		.irq_enable(irq_enable), .fetch_done(fd), .fetch_data(fdat), .store_done(sd), .pkt_done(pkt),
		.crc_err(crc), .par_err(par), .sig_detect(sig), .row_buf(rbuf), .row_addr(radr), .fetch_pending(fpend),
		.store_pending(spend), .event_status(st), .irq_out_n(irq_n));
	sesu_mem_model u_mem (.ref_clk(ref_clk), .rst_n(rst_n), .fetch_cmd(cmd[6]), .store_cmd(cmd[5]),
		.lat(lat), .fetch_done(fd), .fetch_data(fdat), .store_done(sd));
	initial forever #4 ref_clk = ~ref_clk;
	task final_report();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task op(input logic [6:0] c);
		cmd = c;
		@(negedge ref_clk);
		cmd = 0;
	endtask
	task wbit(input int b);
		int i;
		for (i = 0; i < 12 && st[b] !== 1'b1; i++) @(negedge ref_clk);
		chk("status bit", 1, st[b]);
		if (i == 12) final_report();
	endtask
	task clr();
		op(7'h01);
		chk("status cleared", 0, st);
	endtask
	task pkts(input int n, input logic [3:0] c, input logic [3:0] p);
		repeat (n) begin
			pkt = 4'hF;
			crc = c;
			par = p;
			@(negedge ref_clk);
			pkt = 0;
			crc = 0;
			par = 0;
			@(negedge ref_clk);
		end
	endtask
	task s_store();
		op(7'h20);
		chk("store pending", 1, spend);
		wd = 32'h1234_5678;
		op(7'h08);
		wbit(10);
		chk("row_buf kept", 0, rbuf);
		chk("irq disabled", 1, irq_n);
		repeat (3) @(negedge ref_clk);
		chk("sticky", 1, st[10]);
		clr();
		ad = 12'hABC;
		op(7'h04);
		wbit(10);
		chk("row_addr kept", 0, radr);
		clr();
		op(7'h03);
		chk("send error wins clear", 16'h0400, st);
		clr();
		repeat (16) @(negedge ref_clk);
		chk("store done", 0, spend);
		op(7'h08);
		op(7'h04);
		op(7'h02);
		@(negedge ref_clk);
		chk("row_buf written", 32'h1234_5678, rbuf);
		chk("row_addr written", 12'hABC, radr);
		chk("no error", 0, st);
	endtask
	task s_fetch();
		irq_enable = 1;
		lat = 4'h8;
		op(7'h40);
		chk("fetch pending", 1, fpend);
		op(7'h10);
		wbit(10);
		chk("irq low", 0, irq_n);
		repeat (10) @(negedge ref_clk);
		chk("fetched row", 32'hA5C3_0F1E, rbuf);
		chk("fetch done", 0, fpend);
		clr();
		op(7'h10);
		chk("late read no error", 0, st);
		chk("irq high", 1, irq_n);
		mask = 16'h0400;
		op(7'h40);
		op(7'h10);
		wbit(10);
		chk("irq masked", 1, irq_n);
		repeat (10) @(negedge ref_clk);
		clr();
		mask = 0;
	endtask
	task s_oos();
		pkts(7, 4'h1, 4'h0);
		pkts(1, 4'h0, 4'h0);
		pkts(7, 4'h1, 4'h0);
		repeat (4) @(negedge ref_clk);
		chk("seven errors", 0, st);
		pkts(1, 4'h1, 4'h0);
		wbit(11);
		chk("oos irq low", 0, irq_n);
		clr();
		pkts(8, 4'h0, 4'h2);
		wbit(11);
		clr();
	endtask
	task s_sdet();
		sig = 4'h4;
		wbit(12);
		clr();
		sig = 4'h0;
		wbit(12);
		clr();
	endtask
	initial begin
		repeat (12) @(negedge ref_clk);
		chk("reset status", 0, st);
		chk("reset irq", 1, irq_n);
		rst_n = 1;
		@(negedge ref_clk);
		s_store();
		s_fetch();
		s_oos();
		s_sdet();
		final_report();
	end
endmodule
`default_nettype wire
